/* socket_force_cfg.svh */
// Offsets, field positions, reset values and timing counts of the socket force block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef SOCKET_FORCE_CFG_SVH
`define SOCKET_FORCE_CFG_SVH

// Byte offsets within the socket register window
`define OFF_FORCE_EVENT 6'h0C
`define OFF_IRQ_STATUS 6'h14
`define OFF_IRQ_MASK 6'h18
`define OFF_BLOCK_STATUS 6'h1C

// Field positions of the force register
`define BIT_RETEST 14
`define BIT_YV 13
`define BIT_XV 12
`define BIT_3V 11
`define BIT_5V 10
`define BIT_INVALID_REQ 9
`define BIT_LOSS 8
`define BIT_UNRECOG 7
`define BIT_RSVD6 6
`define BIT_CARDBUS 5
`define BIT_SIXTEEN 4
`define BIT_PWR_EVT 3
`define BIT_CD2_EVT 2
`define BIT_CD1_EVT 1
`define BIT_STS_EVT 0
`define FORCE_WMASK 15'h7FBF

// Interrupt status and mask layout
`define IRQ_BIT_RETEST 0
`define IRQ_BIT_PWR_OFF 1
`define IRQ_BIT_FORCED 2
`define IRQ_WIDTH 3

// Reset values
`define RST_PWR_EN 1'h1
`define RST_IRQ_MASK 3'h0

// Fixed answer latency of the register slave, in cycles of wait
`define BUS_WAIT_CYCLES 1

`endif

/* socket_force_pkg.sv */
// Types shared by the socket force block.
// Assumes socket_force_cfg.svh is on the include path.
`include "socket_force_cfg.svh"

package socket_force_pkg;

    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_ANSWER
    } bus_state_t;

    // Write strobes and data toward the present-state register
    typedef struct packed {
        logic [13:0] wr_en;
        logic [13:0] wr_data;
    } present_write_t;

    // Write strobes and data toward the event register
    typedef struct packed {
        logic [3:0] wr_en;
        logic [3:0] wr_data;
    } event_write_t;

    typedef struct packed {
        bus_state_t state;
        logic [31:0] readdata;
        logic readdatavalid;
        logic pwr_en;
        logic retest;
        present_write_t pres;
        event_write_t evt;
        logic [`IRQ_WIDTH-1:0] irq_status;
        logic [`IRQ_WIDTH-1:0] irq_mask;
        logic irq;
    } state_t;

endpackage

/* socket_force_event_register.sv */
// Socket force register: software forces present-state flags and event bits,
// starts a card re-interrogation and gates socket power control.
// Assumes one clock, synchronous reset, Avalon-MM master on the same clock.
//
// How it works
// - Bits 31 to 15 read zero; writes there do nothing.
// - Writing one to bit 14 retests the card and re-enables power control.
// - Bits 13 to 10 write the YV, XV, 3 V, 5 V capability flags.
// - A one in any of bits 13 to 10 disables power control, unless bit 14 is also written one.
// - Bit 9 writes the invalid supply-request flag.
// - Bit 8 writes the possible data-loss flag.
// - Bit 7 writes the unrecognized-card flag.
// - Bit 6 reserved: reads zero, writes ignored.
// - Bit 5 writes the CardBus-detected flag.
// - Bit 4 writes the sixteen-bit-detected flag.
// - Bit 3 writes the power-change event bit; powered flag untouched.
// - Bit 2 writes the second detect event bit; live status untouched.
// - Bit 1 writes the first detect event bit; live status untouched.
// - Bit 0 writes the status-change event bit; live flag untouched.
// - Force register sits at offset 0Ch; its write bits read zero.
// - Capability flags change only by interrogation or forced writes.
`include "socket_force_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module socket_force_event_register #(
    parameter int ADDR_W = 6
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    // Toward the present-state register, bits 13..0 of its layout
    output socket_force_pkg::present_write_t present_write_o,
    // Toward the event register, bits 3..0 of its layout
    output socket_force_pkg::event_write_t event_write_o,
    // One-cycle request to the interrogation machinery
    output logic retest_o,
    // Socket power control allowed
    output logic power_ctrl_en_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (ADDR_W < 6) begin : g_bad_addr
        $error("ADDR_W must be at least 6");
    end

    socket_force_pkg::state_t q, d;

    logic acc;
    logic hit_force;
    logic hit_stat;
    logic hit_mask;
    logic hit_bstat;
    logic [14:0] wd;
    logic [1:0] wr_lo;
    logic cap_one;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.readdatavalid = 1'h0;
        d.retest = 1'h0;
        d.pres.wr_en = 14'h0;
        d.evt.wr_en = 4'h0;
        acc = 1'h0;
        hit_force = 1'h0;
        hit_stat = 1'h0;
        hit_mask = 1'h0;
        hit_bstat = 1'h0;
        wd = writedata_i[14:0];
        wr_lo = byteenable_i[1:0];
        cap_one = 1'h0;
        if (address_i[ADDR_W-1:2] == (`OFF_FORCE_EVENT >> 2)) begin
            hit_force = 1'h1;
        end else if (address_i[ADDR_W-1:2] == (`OFF_IRQ_STATUS >> 2)) begin
            hit_stat = 1'h1;
        end else if (address_i[ADDR_W-1:2] == (`OFF_IRQ_MASK >> 2)) begin
            hit_mask = 1'h1;
        end else if (address_i[ADDR_W-1:2] == (`OFF_BLOCK_STATUS >> 2)) begin
            hit_bstat = 1'h1;
        end
        case (q.state)
            socket_force_pkg::BUS_IDLE: begin
                if (read_i || write_i) begin
                    d.state = socket_force_pkg::BUS_ANSWER;
                end
                // Read data is loaded on entry so it stands while waitrequest is low
                if (read_i) begin
                    d.readdata = 32'h0;
                    if (hit_stat) begin
                        d.readdata[`IRQ_WIDTH-1:0] = q.irq_status;
                    end else if (hit_mask) begin
                        d.readdata[`IRQ_WIDTH-1:0] = q.irq_mask;
                    end else if (hit_bstat) begin
                        d.readdata[0] = q.pwr_en;
                    end
                end
            end
            socket_force_pkg::BUS_ANSWER: begin
                acc = 1'h1;
                d.state = socket_force_pkg::BUS_IDLE;
            end
            default: begin
                d.state = socket_force_pkg::BUS_IDLE;
            end
        endcase
        // Write side effects, taken once at the accepting edge
        if (acc && write_i && hit_force) begin
            if (wr_lo[0]) begin
                // Bit 6 is left out of the strobes
                d.pres.wr_en[`BIT_UNRECOG] = 1'h1;
                d.pres.wr_en[`BIT_CARDBUS] = 1'h1;
                d.pres.wr_en[`BIT_SIXTEEN] = 1'h1;
                d.evt.wr_en[`BIT_PWR_EVT] = 1'h1;
                d.evt.wr_en[`BIT_CD2_EVT] = 1'h1;
                d.evt.wr_en[`BIT_CD1_EVT] = 1'h1;
                d.evt.wr_en[`BIT_STS_EVT] = 1'h1;
            end
            if (wr_lo[1]) begin
                d.pres.wr_en[13:10] = 4'hF;
                d.pres.wr_en[`BIT_INVALID_REQ] = 1'h1;
                d.pres.wr_en[`BIT_LOSS] = 1'h1;
                cap_one = |wd[`BIT_YV:`BIT_5V];
            end
            d.pres.wr_data = wd[13:0] & 14'(`FORCE_WMASK);
            d.evt.wr_data = wd[3:0];
            if (wr_lo[1] && wd[`BIT_RETEST]) begin
                d.retest = 1'h1;
                d.pwr_en = 1'h1;
                d.irq_status[`IRQ_BIT_RETEST] = 1'h1;
            end else if (cap_one) begin
                d.pwr_en = 1'h0;
                d.irq_status[`IRQ_BIT_PWR_OFF] = 1'h1;
            end
            if (|(wd & 15'(`FORCE_WMASK) & {wr_lo[1], {7{wr_lo[1]}}, {7{wr_lo[0]}}})) begin
                d.irq_status[`IRQ_BIT_FORCED] = 1'h1;
            end
        end
        // Write-one-to-clear; events set this cycle win over the clear
        if (acc && write_i && hit_stat && wr_lo[0]) begin
            d.irq_status = (q.irq_status & ~writedata_i[`IRQ_WIDTH-1:0])
                | (d.irq_status & ~q.irq_status);
        end
        if (acc && write_i && hit_mask && wr_lo[0]) begin
            d.irq_mask = writedata_i[`IRQ_WIDTH-1:0];
        end
        if (acc && read_i) begin
            d.readdatavalid = 1'h1;
        end
        d.irq = |(d.irq_status & d.irq_mask);
        if (rst_i) begin
            d.state = socket_force_pkg::BUS_IDLE;
            d.readdata = 32'h0;
            d.readdatavalid = 1'h0;
            d.pwr_en = `RST_PWR_EN;
            d.retest = 1'h0;
            d.pres = '0;
            d.evt = '0;
            d.irq_status = '0;
            d.irq_mask = `RST_IRQ_MASK;
            d.irq = 1'h0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        q <= d;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Waitrequest is low only in the answer state, which is registered
    assign waitrequest_o = (q.state != socket_force_pkg::BUS_ANSWER);
    assign readdata_o = q.readdata;
    assign present_write_o = q.pres;
    assign event_write_o = q.evt;
    assign retest_o = q.retest;
    assign power_ctrl_en_o = q.pwr_en;
    assign irq_o = q.irq;

endmodule // socket_force_event_register

`default_nettype wire

/* sfe_assertions.sv */
// Checker on the ports of the socket force block.
// Assumes it is bound to socket_force_event_register.
`timescale 1ns/1ps
`default_nettype none
module sfe_chk #(parameter int ADDR_W = 6) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    input wire logic [31:0] readdata_o,
    input wire logic waitrequest_o,
    input wire socket_force_pkg::present_write_t present_write_o,
    input wire socket_force_pkg::event_write_t event_write_o,
    input wire logic retest_o,
    input wire logic power_ctrl_en_o
);
    // ----------
    // Force accesses
    // ----------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic fw, fr, hi;
    logic [3:0] be_q;
    logic [13:0] wd_q, en;
    assign fw = write_i && !waitrequest_o && address_i[5:2] == 4'h3;
    assign fr = read_i && !waitrequest_o && address_i[5:2] == 4'h3;
    assign hi = fw && byteenable_i[1];
    assign en = present_write_o.wr_en;
    always_ff @(posedge clk_i) begin
        be_q <= byteenable_i;
        wd_q <= writedata_i[13:0];
    end
    property p_en; fw |=> en == {{6{be_q[1]}}, be_q[0], 1'b0, {2{be_q[0]}}, 4'h0}; endproperty
    a_en: assert property (p_en) else $error("strobes");
    property p_dat; fw |=> (present_write_o.wr_data & en) == (wd_q & en); endproperty
    a_dat: assert property (p_dat) else $error("flag data");
    property p_evt; fw && byteenable_i[0] |=> event_write_o == {4'hF, wd_q[3:0]}; endproperty
    a_evt: assert property (p_evt) else $error("event");
    property p_qt; !$past(fw) |-> en == 14'h0 && event_write_o.wr_en == 4'h0 && !retest_o;
    endproperty
    a_qt: assert property (p_qt) else $error("stray");
    property p_rt; hi && writedata_i[14] |=> retest_o && power_ctrl_en_o; endproperty
    a_rt: assert property (p_rt) else $error("retest");
    property p_off; hi && !writedata_i[14] && writedata_i[13:10] != 4'h0 |=> !power_ctrl_en_o;
    endproperty
    a_off: assert property (p_off) else $error("power off");
    property p_on; $rose(power_ctrl_en_o) |-> retest_o; endproperty
    a_on: assert property (p_on) else $error("power on");
    property p_rd; fr |-> readdata_o == 32'h0; endproperty
    a_rd: assert property (p_rd) else $error("read");
    c_rt: cover property (hi && writedata_i[14]);
    c_off: cover property (hi && writedata_i[13:10] != 4'h0);
    c_rd: cover property (fr);
endmodule // sfe_chk
bind socket_force_event_register sfe_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

/* tb.sv */
// Self-checking bench of the socket force block.
// Assumes package, header, design and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {
        logic [31:0] d;
        logic [3:0] be;
        logic [27:0] pe;
        logic [7:0] ee;
        logic pw;
    } row_t;
    logic clk_i, rst_i, read_i, write_i, waitrequest_o, retest_o, power_ctrl_en_o, irq_o;
    logic [5:0] address_i;
    logic [3:0] byteenable_i;
    logic [31:0] writedata_i, readdata_o, rd;
    socket_force_pkg::present_write_t present_write_o, pw;
    socket_force_pkg::event_write_t event_write_o, ew;
    int failures, compares;
    row_t rows [7];
    socket_force_event_register u_dut (.*);
    // ----------
    // Tasks
    // ----------
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
        input logic [3:0] be);
        int n;
        logic ok;
        n = 0;
        ok = 0;
        @(posedge clk_i);
        address_i <= a;
        writedata_i <= d;
        byteenable_i <= be;
        write_i <= w;
        read_i <= !w;
        while (!ok && n < 20) begin
            @(posedge clk_i);
            ok = waitrequest_o === 1'b0;
            rd = readdata_o;
            n++;
        end
        write_i <= 0;
        read_i <= 0;
        #1;
        pw = present_write_o;
        ew = event_write_o;
        chk("wait", 1, ok);
    endtask
    task automatic rst_end();
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        #1;
        chk("rst", 4'hC, {waitrequest_o, power_ctrl_en_o, irq_o, retest_o});
    endtask
    task automatic test_done();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        clk_i = 0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        #5000;
        failures++;
        test_done();
    end
    initial begin
        rst_i = 1;
        read_i = 0;
        write_i = 0;
        address_i = 0;
        writedata_i = 0;
        byteenable_i = 0;
        rows = '{'{32'h3FBF, 4'h3, {14'h3FB0, 14'h3FB0}, 8'hFF, 1'b0},
            '{32'hFFFF4000, 4'h3, {14'h3FB0, 14'h0}, 8'hF0, 1'b1},
            '{32'h7C00, 4'h2, {14'h3F00, 14'h3C00}, 8'h00, 1'b1},
            '{32'hE5, 4'h1, {14'hB0, 14'hA0}, 8'hF5, 1'b1},
            '{32'h400, 4'h1, {14'hB0, 14'h0}, 8'hF0, 1'b1},
            '{32'h400, 4'h2, {14'h3F00, 14'h400}, 8'h00, 1'b0},
            '{32'h4000, 4'h2, {14'h3F00, 14'h0}, 8'h00, 1'b1}};
        rst_end();
        foreach (rows[i]) begin
            bus(1, 6'h0C, rows[i].d, rows[i].be);
            chk("pres", rows[i].pe, {pw.wr_en, pw.wr_data & pw.wr_en});
            chk("evt", rows[i].ee, {ew.wr_en, ew.wr_data & ew.wr_en});
            chk("retest", rows[i].d[14] & rows[i].be[1], retest_o);
            chk("power", rows[i].pw, power_ctrl_en_o);
        end
        bus(0, 6'h0C, 0, 4'hF);
        chk("force rd", 0, rd);
        bus(1, 6'h24, 32'h7FFF, 4'hF);
        chk("bad wr", 0, {pw.wr_en, ew.wr_en, retest_o});
        bus(0, 6'h24, 0, 4'hF);
        chk("bad rd", 0, rd);
        bus(0, 6'h1C, 0, 4'hF);
        chk("blk", 1, rd);
        bus(0, 6'h18, 0, 4'hF);
        chk("mask", 0, rd);
        bus(0, 6'h14, 0, 4'hF);
        chk("sts", 7, rd);
        chk("irq masked", 0, irq_o);
        bus(1, 6'h18, 4, 4'hF);
        @(posedge clk_i);
        #1;
        chk("irq", 1, irq_o);
        bus(1, 6'h14, 7, 4'hF);
        @(posedge clk_i);
        #1;
        chk("irq clr", 0, irq_o);
        bus(1, 6'h0C, 32'h400, 4'h2);
        chk("pwr off", 0, power_ctrl_en_o);
        bus(1, 6'h0C, 32'h4400, 4'h2);
        chk("pwr back", 1, power_ctrl_en_o);
        chk("retest back", 1, retest_o);
        rst_i <= 1;
        rst_end();
        test_done();
    end
endmodule // tb
`default_nettype wire
